// File: logic/flc_loop_config.sv
// Functional notes
// - Bit 15 of first register enables loop digital section, 1 enables.
// - Bit 14 of first register enables loop analogue oscillator, 1 enables.
// - Bits 10:8 divide oscillator by 2,4,8,16,32; codes 101-111 reserved.
// - Bits 7:4 set loop gain x1 to x256 in powers of two.
// - Bits 2:0 clock control block at oscillator divided by 1 to 32.
// - Bits 15:11 of second register divide oscillator; valid 1 to 31, default 14.
// - Bits 9:0 of second register hold integer multiplier, default 086h.
// - Fractional multiplier, default c226h, used only in fractional mode.
// - Bit 7 selects high (0) or low (1) frequency reference locking.
// - Bit 5 selects integer (0) or fractional (1) mode.
// - Bits 1:0 pick reference: master clock, DAC frame, ADC frame, 32k.
// - System clock source select routes master clock (0) or loop output (1).
`timescale 1ns/1ns
`default_nettype none
`include "flc_params.svh"
module flc_loop_config #(
	parameter int DATA_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire flc_pkg::flc_reg_req_t reg_req,
	output logic [15:0] reg_rdata_r,
	output logic reg_rvalid_r,
	input wire flc_pkg::flc_ref_pins_t ref_pins,
	input wire logic oscillator_clock,
	input wire logic codec_system_clock_source_select,
	output logic loop_digital_enable_r,
	output logic loop_analog_enable_r,
	output logic low_ref_lock_select_r,
	output logic loop_ref_clock_r,
	output logic loop_clock_r,
	output logic codec_system_clock_r,
	output logic ctrl_tick_r,
	output logic prescale_tick_r,
	output logic [8:0] gain_mult_r,
	output logic [9:0] integer_multiplier_r,
	output logic [15:0] fractional_multiplier_r
);
	import flc_pkg::*;

	if (DATA_W != 16) begin : g_bad_width
		$error("flc_loop_config supports only 16-bit registers");
	end

	logic [15:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt, ctl4_r, ctl4_nxt;
	logic [15:0] rdata_nxt;
	logic rvalid_nxt;

	// Register file
	always_comb begin
		ctl1_nxt = ctl1_r;
		ctl2_nxt = ctl2_r;
		ctl3_nxt = ctl3_r;
		ctl4_nxt = ctl4_r;
		rdata_nxt = reg_rdata_r;
		rvalid_nxt = reg_req.rd;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`FLC_ADDR_ENA_DIV: ctl1_nxt = reg_req.wdata & `FLC_MASK_ENA_DIV;
				`FLC_ADDR_RATIO_INT: ctl2_nxt = reg_req.wdata & `FLC_MASK_RATIO_INT;
				`FLC_ADDR_FRACTION: ctl3_nxt = reg_req.wdata & `FLC_MASK_FRACTION;
				`FLC_ADDR_REFERENCE: ctl4_nxt = reg_req.wdata & `FLC_MASK_REFERENCE;
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`FLC_ADDR_ENA_DIV: rdata_nxt = ctl1_r;
				`FLC_ADDR_RATIO_INT: rdata_nxt = ctl2_r;
				`FLC_ADDR_FRACTION: rdata_nxt = ctl3_r;
				`FLC_ADDR_REFERENCE: rdata_nxt = ctl4_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl1_r <= `FLC_RST_ENA_DIV;
			ctl2_r <= `FLC_RST_RATIO_INT;
			ctl3_r <= `FLC_RST_FRACTION;
			ctl4_r <= `FLC_RST_REFERENCE;
			reg_rdata_r <= 16'h0000;
			reg_rvalid_r <= 1'b0;
		end else begin
			ctl1_r <= ctl1_nxt;
			ctl2_r <= ctl2_nxt;
			ctl3_r <= ctl3_nxt;
			ctl4_r <= ctl4_nxt;
			reg_rdata_r <= rdata_nxt;
			reg_rvalid_r <= rvalid_nxt;
		end
	end

	// Field decode
	logic dig_ena, ana_ena, frac_mode, run;
	logic [2:0] outdiv, rate;
	logic [3:0] gain;
	logic [4:0] ratio;
	flc_ref_src_t src;
	assign dig_ena = ctl1_r[`FLC_BIT_DIG_ENA];
	assign ana_ena = ctl1_r[`FLC_BIT_ANA_ENA];
	assign outdiv = ctl1_r[`FLC_OUTDIV_HI:`FLC_OUTDIV_LO];
	assign gain = ctl1_r[`FLC_GAIN_HI:`FLC_GAIN_LO];
	assign rate = ctl1_r[`FLC_RATE_HI:`FLC_RATE_LO];
	assign ratio = ctl2_r[`FLC_RATIO_HI:`FLC_RATIO_LO];
	assign frac_mode = ctl4_r[`FLC_BIT_FRAC];
	assign src = flc_ref_src_t'(ctl4_r[`FLC_SRC_HI:`FLC_SRC_LO]);
	// Digital logic only counts when the oscillator is running too; this also covers a misordered enable
	assign run = dig_ena && ana_ena && oscillator_clock;

	// Clock generation state
	logic [4:0] osc_cnt_r, osc_cnt_nxt, pre_cnt_r, pre_cnt_nxt;
	logic [4:0] half_mask, rate_mask;
	logic loop_clock_nxt, ctrl_tick_nxt, prescale_tick_nxt, ref_nxt, sys_nxt;
	logic [8:0] gain_nxt;
	logic [15:0] frac_nxt;

	always_comb begin
		half_mask = (5'h01 << outdiv) - 5'h01;
		rate_mask = (rate > `FLC_RATE_MAX) ? 5'h1f : (5'h01 << rate) - 5'h01;
		osc_cnt_nxt = osc_cnt_r;
		pre_cnt_nxt = pre_cnt_r;
		loop_clock_nxt = loop_clock_r;
		ctrl_tick_nxt = 1'b0;
		prescale_tick_nxt = 1'b0;
		if (!dig_ena) begin
			osc_cnt_nxt = 5'h00;
			pre_cnt_nxt = 5'h00;
			loop_clock_nxt = 1'b0;
		end else if (run) begin
			osc_cnt_nxt = osc_cnt_r + 5'h01;
			// Reserved divider codes hold the output still rather than guess a ratio
			if (outdiv <= `FLC_OUTDIV_MAX && (osc_cnt_r & half_mask) == half_mask) begin
				loop_clock_nxt = !loop_clock_r;
			end
			ctrl_tick_nxt = (osc_cnt_r & rate_mask) == rate_mask;
			// Ratio zero is invalid: no prescaled pulse at all
			if (ratio != 5'h00) begin
				if (pre_cnt_r + 5'h01 >= ratio) begin
					pre_cnt_nxt = 5'h00;
					prescale_tick_nxt = 1'b1;
				end else begin
					pre_cnt_nxt = pre_cnt_r + 5'h01;
				end
			end
		end
		// Codes above x256 saturate
		gain_nxt = (gain > `FLC_GAIN_MAX) ? 9'h100 : 9'h001 << gain;
		frac_nxt = frac_mode ? ctl3_r : 16'h0000;
		unique case (src)
			FLC_SRC_MCLK: ref_nxt = ref_pins.mclk_pin;
			FLC_SRC_DAC_FRAME: ref_nxt = ref_pins.dac_frame_clock;
			FLC_SRC_ADC_FRAME: ref_nxt = ref_pins.adc_frame_clock;
			FLC_SRC_32K: ref_nxt = ref_pins.crystal_32k_reference;
		endcase
		sys_nxt = codec_system_clock_source_select ? loop_clock_r : ref_pins.mclk_pin;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			osc_cnt_r <= 5'h00;
			pre_cnt_r <= 5'h00;
			loop_clock_r <= 1'b0;
			ctrl_tick_r <= 1'b0;
			prescale_tick_r <= 1'b0;
			gain_mult_r <= 9'h001;
			fractional_multiplier_r <= 16'h0000;
			integer_multiplier_r <= 10'(`FLC_RST_RATIO_INT);
			loop_ref_clock_r <= 1'b0;
			codec_system_clock_r <= 1'b0;
			loop_digital_enable_r <= 1'b0;
			loop_analog_enable_r <= 1'b0;
			low_ref_lock_select_r <= 1'b0;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
			pre_cnt_r <= pre_cnt_nxt;
			loop_clock_r <= loop_clock_nxt;
			ctrl_tick_r <= ctrl_tick_nxt;
			prescale_tick_r <= prescale_tick_nxt;
			gain_mult_r <= gain_nxt;
			fractional_multiplier_r <= frac_nxt;
			integer_multiplier_r <= ctl2_r[`FLC_INT_HI:`FLC_INT_LO];
			loop_ref_clock_r <= ref_nxt;
			codec_system_clock_r <= sys_nxt;
			loop_digital_enable_r <= dig_ena;
			loop_analog_enable_r <= ana_ena;
			low_ref_lock_select_r <= ctl4_r[`FLC_BIT_LOW_REF];
		end
	end

	a_digital_follows_bit: assert property (@(posedge ref_clk) disable iff (rst)
		loop_digital_enable_r == $past(ctl1_r[`FLC_BIT_DIG_ENA])) else $error("digital enable mismatch");
	a_analog_follows_write: assert property (@(posedge ref_clk) disable iff (rst)
		reg_req.wr && reg_req.addr == `FLC_ADDR_ENA_DIV |=> ##1 loop_analog_enable_r == $past(reg_req.wdata[14], 2))
		else $error("analog enable mismatch");
	a_clock_idle_off: assert property (@(posedge ref_clk) disable iff (rst)
		!dig_ena |=> !loop_clock_r && !ctrl_tick_r && !prescale_tick_r) else $error("clock runs while disabled");
	a_div2_toggles: assert property (@(posedge ref_clk) disable iff (rst)
		dig_ena && ana_ena && oscillator_clock && outdiv == 3'h0 |=> loop_clock_r != $past(loop_clock_r))
		else $error("divide by 2 not toggling");
	a_reserved_div_holds: assert property (@(posedge ref_clk) disable iff (rst)
		dig_ena && outdiv > `FLC_OUTDIV_MAX |=> $stable(loop_clock_r)) else $error("reserved divider moved");
	a_gain_power: assert property (@(posedge ref_clk) disable iff (rst)
		gain <= `FLC_GAIN_MAX |=> gain_mult_r == (9'h001 << $past(gain))) else $error("gain wrong");
	a_rate_one_tick: assert property (@(posedge ref_clk) disable iff (rst)
		run && rate == 3'h0 |=> ctrl_tick_r) else $error("rate 1 missed a tick");
	a_ratio_one_tick: assert property (@(posedge ref_clk) disable iff (rst)
		run && ratio == 5'h01 |=> prescale_tick_r) else $error("ratio 1 missed a tick");
	a_fraction_gated: assert property (@(posedge ref_clk) disable iff (rst)
		!frac_mode |=> fractional_multiplier_r == 16'h0000) else $error("fraction used in integer mode");
	a_codec_system_clock_route: assert property (@(posedge ref_clk) disable iff (rst)
		codec_system_clock_source_select |=> codec_system_clock_r == $past(loop_clock_r)) else $error("system clock route wrong");
	a_ref_select: assert property (@(posedge ref_clk) disable iff (rst)
		src == FLC_SRC_32K |=> loop_ref_clock_r == $past(ref_pins.crystal_32k_reference)) else $error("reference mux");
	a_readback_write: assert property (@(posedge ref_clk) disable iff (rst)
		reg_req.wr && reg_req.addr == `FLC_ADDR_FRACTION ##1 reg_req.rd && reg_req.addr == `FLC_ADDR_FRACTION
		|=> reg_rvalid_r && reg_rdata_r == $past(reg_req.wdata, 2)) else $error("readback mismatch");

	c_loop_running: cover property (@(posedge ref_clk) disable iff (rst) run ##1 ctrl_tick_r);
	c_frac_mode: cover property (@(posedge ref_clk) disable iff (rst) frac_mode && dig_ena);
	c_codec_system_clock_loop: cover property (@(posedge ref_clk) disable iff (rst) codec_system_clock_source_select && loop_clock_r);
	c_prescale: cover property (@(posedge ref_clk) disable iff (rst) prescale_tick_r);
endmodule
`default_nettype wire

// File: logic/flc_params.svh
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH
`define FLC_ADDR_ENA_DIV 8'h2a
`define FLC_ADDR_RATIO_INT 8'h2b
`define FLC_ADDR_FRACTION 8'h2c
`define FLC_ADDR_REFERENCE 8'h2d
`define FLC_RST_ENA_DIV 16'h0200
`define FLC_RST_RATIO_INT 16'h7086
`define FLC_RST_FRACTION 16'hc226
`define FLC_RST_REFERENCE 16'h0000
`define FLC_MASK_ENA_DIV 16'hc7f7
`define FLC_MASK_RATIO_INT 16'hfbff
`define FLC_MASK_FRACTION 16'hffff
`define FLC_MASK_REFERENCE 16'h00a3
`define FLC_BIT_DIG_ENA 15
`define FLC_BIT_ANA_ENA 14
`define FLC_OUTDIV_HI 10
`define FLC_OUTDIV_LO 8
`define FLC_GAIN_HI 7
`define FLC_GAIN_LO 4
`define FLC_RATE_HI 2
`define FLC_RATE_LO 0
`define FLC_RATIO_HI 15
`define FLC_RATIO_LO 11
`define FLC_INT_HI 9
`define FLC_INT_LO 0
`define FLC_BIT_LOW_REF 7
`define FLC_BIT_FRAC 5
`define FLC_SRC_HI 1
`define FLC_SRC_LO 0
`define FLC_OUTDIV_MAX 3'h4
`define FLC_GAIN_MAX 4'h8
`define FLC_RATE_MAX 3'h5
`endif

// File: logic/flc_pkg.sv
package flc_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} flc_reg_req_t;
	typedef enum logic [1:0] {
		FLC_SRC_MCLK,
		FLC_SRC_DAC_FRAME,
		FLC_SRC_ADC_FRAME,
		FLC_SRC_32K
	} flc_ref_src_t;
	typedef struct packed {
		logic mclk_pin;
		logic dac_frame_clock;
		logic adc_frame_clock;
		logic crystal_32k_reference;
	} flc_ref_pins_t;
endpackage

// File: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "flc_params.svh"
module tb_top;
	import flc_pkg::*;
	logic ref_clk, rst, oscillator_clock, codec_system_clock_source_select;
	flc_reg_req_t reg_req;
	flc_ref_pins_t ref_pins;
	logic [15:0] reg_rdata_r, fractional_multiplier_r, rv, x;
	logic reg_rvalid_r, loop_digital_enable_r, loop_analog_enable_r, low_ref_lock_select_r;
	logic loop_ref_clock_r, loop_clock_r, codec_system_clock_r, ctrl_tick_r, prescale_tick_r;
	logic [8:0] gain_mult_r;
	logic [9:0] integer_multiplier_r;
	int miscompares, checks_done;
	logic [7:0] adr [4] = '{`FLC_ADDR_ENA_DIV, `FLC_ADDR_RATIO_INT, `FLC_ADDR_FRACTION, `FLC_ADDR_REFERENCE};
	logic [15:0] rst_v [4] = '{`FLC_RST_ENA_DIV, `FLC_RST_RATIO_INT, `FLC_RST_FRACTION, `FLC_RST_REFERENCE};
	logic [15:0] msk [4] = '{`FLC_MASK_ENA_DIV, `FLC_MASK_RATIO_INT, `FLC_MASK_FRACTION, `FLC_MASK_REFERENCE};
	int ratios [4] = '{1, 8, 14, 31};
	flc_loop_config i_flc_loop_config (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .ref_pins(ref_pins),
		.oscillator_clock(oscillator_clock), .codec_system_clock_source_select(codec_system_clock_source_select),
		.loop_digital_enable_r(loop_digital_enable_r), .loop_analog_enable_r(loop_analog_enable_r),
		.low_ref_lock_select_r(low_ref_lock_select_r), .loop_ref_clock_r(loop_ref_clock_r),
		.loop_clock_r(loop_clock_r), .codec_system_clock_r(codec_system_clock_r),
		.ctrl_tick_r(ctrl_tick_r), .prescale_tick_r(prescale_tick_r), .gain_mult_r(gain_mult_r),
		.integer_multiplier_r(integer_multiplier_r), .fractional_multiplier_r(fractional_multiplier_r));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic end_of_test;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1;
		check({15'h0000, reg_rvalid_r}, 16'h0001);
		d = reg_rdata_r;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return loop_clock_r;
			1: return ctrl_tick_r;
			default: return prescale_tick_r;
		endcase
	endfunction
	// Gap between two events; toggles for the loop clock, pulses for the ticks
	task automatic gap(input int s, input int exp);
		logic prev;
		int n, k;
		n = 0;
		k = 0;
		cyc(1);
		prev = pick(s);
		while (k < 2 && n < 300) begin
			cyc(1);
			n++;
			if (s == 0 ? pick(s) !== prev : pick(s) === 1'b1) begin
				if (k == 0)
					n = 0;
				k++;
			end
			prev = pick(s);
		end
		if (k < 2) begin
			miscompares++;
			end_of_test();
		end else begin
			check(n[15:0], exp[15:0]);
		end
	endtask
	initial begin
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		oscillator_clock = 1'b0;
		codec_system_clock_source_select = 1'b0;
		reg_req = '0;
		ref_pins = '0;
		void'($urandom(58));
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(2);
		for (int i = 0; i < 4; i++) begin
			rd(adr[i], rv);
			check(rv, rst_v[i]);
		end
		check({7'h00, gain_mult_r}, 16'h0001);
		check(fractional_multiplier_r, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			x = 16'($urandom);
			// Software never turns digital on without analogue
			if (i % 4 == 0 && x[`FLC_BIT_DIG_ENA])
				x[`FLC_BIT_ANA_ENA] = 1'b1;
			wr(adr[i % 4], x);
			rd(adr[i % 4], rv);
			check(rv, x & msk[i % 4]);
		end
		rd(8'h2e, rv);
		check(rv, 16'h0000);
		// Write then read on consecutive edges, no idle cycle between
		x = 16'($urandom);
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: `FLC_ADDR_FRACTION, wdata: x};
		@(posedge ref_clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: `FLC_ADDR_FRACTION, wdata: 16'h0000};
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1;
		check({15'h0000, reg_rvalid_r}, 16'h0001);
		check(reg_rdata_r, x);
		// Gain moved off default on purpose, only to reach codes 0 to 9
		for (int g = 0; g < 10; g++) begin
			wr(8'h2a, 16'h0200 | (16'(g) << 4));
			cyc(2);
			check({7'h00, gain_mult_r}, (g > 8) ? 16'h0100 : (16'h0001 << g));
		end
		x = 16'($urandom);
		wr(8'h2b, 16'h7000 | {6'h00, x[9:0]});
		wr(8'h2c, x);
		cyc(2);
		check({6'h00, integer_multiplier_r}, {6'h00, x[9:0]});
		for (int s = 0; s < 8; s++) begin
			wr(8'h2d, {8'h00, s[2], 1'b0, s[1] ^ s[0], 3'h0, s[1:0]});
			for (int k = 0; k < 3; k++) begin
				@(posedge ref_clk);
				ref_pins <= flc_ref_pins_t'(4'($urandom));
				cyc(3);
				check({15'h0000, loop_ref_clock_r}, {15'h0000, ref_pins[3 - s[1:0]]});
			end
			check({15'h0000, low_ref_lock_select_r}, {15'h0000, s[2]});
			check(fractional_multiplier_r, (s[1] ^ s[0]) ? x : 16'h0000);
		end
		@(posedge ref_clk);
		oscillator_clock <= 1'b1;
		// Both enables in one write, never digital alone
		for (int d = 0; d < 5; d++) begin
			wr(8'h2a, 16'hc000 | (16'(d) << 8));
			gap(0, 1 << d);
		end
		check({14'h0000, loop_digital_enable_r, loop_analog_enable_r}, 16'h0003);
		for (int r = 0; r < 6; r++) begin
			wr(8'h2a, 16'hc200 | 16'(r));
			gap(1, 1 << r);
		end
		for (int q = 0; q < 4; q++) begin
			wr(8'h2b, (16'(ratios[q]) << 11) | 16'h0086);
			gap(2, ratios[q]);
		end
		// Reserved divider code must freeze the output where it stands
		wr(8'h2a, 16'hc500);
		cyc(1);
		rv[0] = loop_clock_r;
		cyc(40);
		check({15'h0000, loop_clock_r}, {15'h0000, rv[0]});
		wr(8'h2a, 16'h4200);
		cyc(3);
		check({13'h0000, loop_digital_enable_r, loop_analog_enable_r, loop_clock_r}, 16'h0002);
		@(posedge ref_clk);
		ref_pins <= 4'h8;
		codec_system_clock_source_select <= 1'b1;
		cyc(3);
		check({15'h0000, codec_system_clock_r}, 16'h0000);
		@(posedge ref_clk);
		codec_system_clock_source_select <= 1'b0;
		cyc(3);
		check({15'h0000, codec_system_clock_r}, 16'h0001);
		// Reset with digital off and analogue on must clear the analogue enable and restore all four register defaults
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(1);
		check({15'h0000, loop_analog_enable_r}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			rd(adr[i], rv);
			check(rv, rst_v[i]);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
